// >>> src/uabg_pkg.sv
package uabg_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_STA = 4'h0;
    localparam logic [3:0] ADDR_BRG = 4'h1;
    localparam logic [3:0] ADDR_CFG = 4'h2;
    localparam logic [3:0] ADDR_TXD = 4'h3;
    localparam logic [3:0] ADDR_RXD = 4'h4;
    // serial_status_control fields
    localparam int B_TXM1  = 15;
    localparam int B_INV   = 14;
    localparam int B_TXM0  = 13;
    localparam int B_BRK   = 11;
    localparam int B_TXEN  = 10;
    localparam int B_TXBF  = 9;
    localparam int B_SH_EMPTY = 8;
    localparam int B_RXM1  = 7;
    localparam int B_RXM0  = 6;
    localparam int B_RIDLE = 4;
    localparam int B_OVR   = 1;
    localparam int B_RXDA  = 0;
    // configuration fields
    localparam int B_HS    = 0;
    localparam int B_IR_EN = 1;
    localparam int B_PEN   = 2;
    // reset values
    localparam logic [15:0] BRG_RST = 16'h0000;
    localparam logic [2:0]  CFG_RST = 3'h0;
    // oversampling ticks per bit and data/break bit counts, last index; infrared pulse length in ticks
    localparam logic [4:0] OS_LO_MAX = 5'h0f;
    localparam logic [4:0] OS_HI_MAX = 5'h03;
    localparam logic [4:0] IR_PULSE  = 5'h03;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [3:0] BRK_LAST  = 4'hb;
    // transmit interrupt modes
    localparam logic [1:0] TXM_LOAD  = 2'h0;
    localparam logic [1:0] TXM_DONE  = 2'h1;
    localparam logic [1:0] TXM_EMPTY = 2'h2;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } uabg_req_t;

    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_BRK, TX_STOP
    } uabg_tx_t;

    typedef enum logic [1:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP
    } uabg_rx_t;
endpackage

// >>> src/uabg_fifo.sv
`timescale 1ns/1ns
module uabg_fifo
#(
    parameter int W     = 8,
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH + 1)
)
(
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    input  wire logic          flush_in,
    input  wire logic          push_in,
    input  wire logic [W-1:0]  wdata_in,
    input  wire logic          pop_in,
    output logic      [W-1:0]  rdata_out,
    output logic      [CW-1:0] count_out,
    output logic               full_out,
    output logic               empty_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic          do_push;
    logic          do_pop;

    assign do_push   = push_in && !full_out;
    assign do_pop    = pop_in && !empty_out;
    assign full_out  = cnt_q == CW'(DEPTH);
    assign empty_out = cnt_q == '0;
    assign count_out = cnt_q;
    assign rdata_out = mem_q[rp_q];

    always_ff @(posedge clk_in)
    begin
        if (do_push)
        begin
            mem_q[wp_q] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in || flush_in)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (do_pop)
            begin
                rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule

// >>> src/uabg_top.sv
`timescale 1ns/1ns
module uabg_top
#(
    parameter int TX_DEPTH = 4,
    parameter int RX_DEPTH = 4
)
(
    input  wire logic                sys_clk_in,
    input  wire logic                rst_b_in,
    input  wire uabg_pkg::uabg_req_t reg_req_in,
    output logic              [15:0] rd_data_out,
    input  wire logic                serial_rx_in,
    output logic                     serial_tx_pin_out,
    output logic                     serial_tx_oe_out,
    output logic                     tx_irq_out,
    output logic                     rx_irq_out
);
    import uabg_pkg::*;
    localparam int TCW = $clog2(TX_DEPTH + 1);
    localparam int RCW = $clog2(RX_DEPTH + 1);

    // software state
    logic [15:0]  baud_divisor_q;
    logic [2:0]   cfg_q;
    logic [1:0]   tx_irq_mode_sel_q;
    logic         tx_idle_polarity_q;
    logic         tx_break_request_q;
    logic         tx_enable_bit_q;
    logic [1:0]   rx_irq_mode_sel_q;
    logic         rx_overrun_flag_q;
    // baud and transmit state
    logic [15:0]  brg_cnt_q;
    logic [4:0]   tx_os_q;
    uabg_tx_t     tx_st_q;
    logic [3:0]   tx_cnt_q;
    logic [7:0]   tx_shift_register_q;
    logic         brk_mode_q;
    // receive state
    logic         rx_s1_q;
    logic         rx_s2_q;
    uabg_rx_t     rx_st_q;
    logic [4:0]   rx_os_q;
    logic [3:0]   rx_cnt_q;
    logic [7:0]   rx_shift_register_q;

    // register port decode
    logic         sta_wr;
    logic         brg_wr;
    logic         cfg_wr;
    logic         txd_wr;
    logic         rxd_rd;
    logic         high_speed_baud_select;
    logic         infrared_encode_enable;
    logic         serial_port_enable;
    assign sta_wr = reg_req_in.wr && reg_req_in.addr == ADDR_STA;
    assign brg_wr = reg_req_in.wr && reg_req_in.addr == ADDR_BRG;
    assign cfg_wr = reg_req_in.wr && reg_req_in.addr == ADDR_CFG;
    assign txd_wr = reg_req_in.wr && reg_req_in.addr == ADDR_TXD;
    assign rxd_rd = reg_req_in.rd && reg_req_in.addr == ADDR_RXD;
    assign high_speed_baud_select = cfg_q[B_HS];
    assign infrared_encode_enable = cfg_q[B_IR_EN];
    assign serial_port_enable     = cfg_q[B_PEN];

    // baud timing
    logic         brg_tick;
    logic [4:0]   os_max;
    logic         bit_tick;
    assign brg_tick = serial_port_enable && brg_cnt_q == baud_divisor_q;
    assign os_max   = high_speed_baud_select ? OS_HI_MAX : OS_LO_MAX;
    assign bit_tick = brg_tick && tx_os_q == os_max;

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in || brg_wr || brg_tick)
        begin
            brg_cnt_q <= '0;
        end
        else if (serial_port_enable)
        begin
            brg_cnt_q <= brg_cnt_q + 16'h1;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in || brg_wr)
        begin
            tx_os_q <= '0;
        end
        else if (brg_tick)
        begin
            tx_os_q <= (tx_os_q == os_max) ? 5'h00 : tx_os_q + 5'h01;
        end
    end

    // transmit buffer
    logic [7:0]   txf_data;
    logic [TCW-1:0] txf_count;
    logic         txf_full;
    logic         txf_empty;
    logic         tx_load;
    logic         tx_push;
    assign tx_push = txd_wr && tx_enable_bit_q;
    assign tx_load = tx_st_q == TX_IDLE && bit_tick && tx_enable_bit_q
                     && !tx_break_request_q && !txf_empty;

    uabg_fifo #(.W(8), .DEPTH(TX_DEPTH)) u_txf (
        .clk_in    (sys_clk_in),
        .rst_b_in  (rst_b_in),
        .flush_in  (!tx_enable_bit_q),
        .push_in   (tx_push),
        .wdata_in  (reg_req_in.wdata[7:0]),
        .pop_in    (tx_load),
        .rdata_out (txf_data),
        .count_out (txf_count),
        .full_out  (txf_full),
        .empty_out (txf_empty)
    );

    // transmit sequencer
    logic         brk_start;
    logic         frame_end;
    logic         brk_clr;
    assign brk_start = tx_st_q == TX_IDLE && bit_tick && tx_enable_bit_q
                       && tx_break_request_q;
    assign frame_end = tx_st_q == TX_STOP && bit_tick;
    assign brk_clr   = frame_end && brk_mode_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in || !tx_enable_bit_q)
        begin
            tx_st_q    <= TX_IDLE;
            tx_cnt_q   <= '0;
            brk_mode_q <= 1'b0;
            tx_shift_register_q <= '0;
        end
        else if (bit_tick)
        begin
            case (tx_st_q)
                TX_IDLE:
                begin
                    if (brk_start || tx_load)
                    begin
                        tx_st_q    <= TX_START;
                        brk_mode_q <= brk_start;
                        tx_shift_register_q <= txf_data;
                    end
                end
                TX_START:
                begin
                    tx_cnt_q <= '0;
                    tx_st_q  <= brk_mode_q ? TX_BRK : TX_DATA;
                end
                TX_DATA:
                begin
                    tx_shift_register_q <= tx_shift_register_q >> 1;
                    tx_cnt_q <= tx_cnt_q + 4'h1;
                    if (tx_cnt_q == DATA_LAST)
                    begin
                        tx_st_q <= TX_STOP;
                    end
                end
                TX_BRK:
                begin
                    tx_cnt_q <= tx_cnt_q + 4'h1;
                    if (tx_cnt_q == BRK_LAST)
                    begin
                        tx_st_q <= TX_STOP;
                    end
                end
                TX_STOP:
                begin
                    tx_st_q    <= TX_IDLE;
                    brk_mode_q <= 1'b0;
                end
                default:
                begin
                    tx_st_q <= TX_IDLE;
                end
            endcase
        end
    end

    // line level and infrared encoding
    logic         txd_raw;
    logic         ir_pulse;
    logic         tx_line;
    logic         tx_irq_d;
    logic         tx_shifter_empty_flag;
    assign txd_raw = tx_st_q == TX_IDLE || tx_st_q == TX_STOP
                     || (tx_st_q == TX_DATA && tx_shift_register_q[0]);
    assign ir_pulse = !txd_raw && tx_os_q < IR_PULSE;
    assign tx_line = infrared_encode_enable
                     ? (ir_pulse ^ tx_idle_polarity_q) : txd_raw;
    assign tx_shifter_empty_flag = tx_st_q == TX_IDLE && txf_empty;
    assign tx_irq_d =
        (tx_irq_mode_sel_q == TXM_LOAD && tx_load)
        || (tx_irq_mode_sel_q == TXM_EMPTY && tx_load
            && txf_count == TCW'(1))
        || (tx_irq_mode_sel_q == TXM_DONE && frame_end
            && txf_empty);

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            serial_tx_pin_out <= 1'b1;
            serial_tx_oe_out  <= 1'b0;
            tx_irq_out        <= 1'b0;
        end
        else
        begin
            serial_tx_pin_out <= tx_enable_bit_q ? tx_line : 1'b1;
            serial_tx_oe_out  <= tx_enable_bit_q;
            tx_irq_out        <= tx_irq_d;
        end
    end

    // receive path
    logic [7:0]   rxf_data;
    logic [RCW-1:0] rxf_count;
    logic         rxf_full;
    logic         rxf_empty;
    logic         rx_push;
    logic         rx_irq_d;
    logic         ovr_set;
    assign rx_push = rx_st_q == RX_STOP && brg_tick && rx_os_q == os_max;
    assign ovr_set = rx_push && rxf_full;
    assign rx_irq_d = rx_push && !rxf_full && (!rx_irq_mode_sel_q[1]
        || (rx_irq_mode_sel_q[0] && rxf_count == RCW'(RX_DEPTH - 1))
        || (!rx_irq_mode_sel_q[0]
            && rxf_count == RCW'(RX_DEPTH - 2)));

    uabg_fifo #(.W(8), .DEPTH(RX_DEPTH)) u_rxf (
        .clk_in    (sys_clk_in),
        .rst_b_in  (rst_b_in),
        .flush_in  (1'b0),
        .push_in   (rx_push),
        .wdata_in  (rx_shift_register_q),
        .pop_in    (rxd_rd),
        .rdata_out (rxf_data),
        .count_out (rxf_count),
        .full_out  (rxf_full),
        .empty_out (rxf_empty)
    );

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= serial_rx_in;
            rx_s2_q <= rx_s1_q;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in || !serial_port_enable)
        begin
            rx_st_q  <= RX_IDLE;
            rx_os_q  <= '0;
            rx_cnt_q <= '0;
            rx_shift_register_q <= '0;
        end
        else if (rx_st_q == RX_IDLE)
        begin
            rx_os_q <= '0;
            if (!rx_s2_q)
            begin
                rx_st_q <= RX_START;
            end
        end
        else if (brg_tick)
        begin
            rx_os_q <= rx_os_q + 5'h01;
            case (rx_st_q)
                RX_START:
                begin
                    if (rx_os_q == (os_max >> 1))
                    begin
                        rx_os_q  <= '0;
                        rx_cnt_q <= '0;
                        rx_st_q  <= rx_s2_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (rx_os_q == os_max)
                    begin
                        rx_os_q  <= '0;
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        rx_shift_register_q <=
                            {rx_s2_q, rx_shift_register_q[7:1]};
                        if (rx_cnt_q == DATA_LAST)
                        begin
                            rx_st_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    if (rx_os_q == os_max)
                    begin
                        rx_st_q <= RX_IDLE;
                    end
                end
                default:
                begin
                    rx_st_q <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            rx_irq_out <= 1'b0;
        end
        else
        begin
            rx_irq_out <= rx_irq_d;
        end
    end

    // software registers
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            baud_divisor_q <= BRG_RST;
            cfg_q          <= CFG_RST;
        end
        else
        begin
            if (brg_wr)
            begin
                baud_divisor_q <= reg_req_in.wdata;
            end
            if (cfg_wr)
            begin
                cfg_q <= reg_req_in.wdata[2:0];
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            tx_irq_mode_sel_q  <= '0;
            tx_idle_polarity_q <= 1'b0;
            tx_enable_bit_q    <= 1'b0;
            rx_irq_mode_sel_q  <= '0;
        end
        else if (sta_wr)
        begin
            tx_irq_mode_sel_q  <= {reg_req_in.wdata[B_TXM1],
                                   reg_req_in.wdata[B_TXM0]};
            tx_idle_polarity_q <= reg_req_in.wdata[B_INV];
            tx_enable_bit_q    <= reg_req_in.wdata[B_TXEN];
            rx_irq_mode_sel_q  <= {reg_req_in.wdata[B_RXM1],
                                   reg_req_in.wdata[B_RXM0]};
        end
    end

    // hardware-cleared and software-cleared flags; a set always wins
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            tx_break_request_q <= 1'b0;
            rx_overrun_flag_q  <= 1'b0;
        end
        else
        begin
            if (sta_wr)
            begin
                tx_break_request_q <= reg_req_in.wdata[B_BRK];
            end
            else if (brk_clr)
            begin
                tx_break_request_q <= 1'b0;
            end
            if (ovr_set)
            begin
                rx_overrun_flag_q <= 1'b1;
            end
            else if (sta_wr && !reg_req_in.wdata[B_OVR])
            begin
                rx_overrun_flag_q <= 1'b0;
            end
        end
    end

    // read mux
    logic [15:0]  sta_view;
    logic [15:0]  rd_mux;
    assign sta_view = {tx_irq_mode_sel_q[1], tx_idle_polarity_q,
                       tx_irq_mode_sel_q[0], 1'b0, tx_break_request_q,
                       tx_enable_bit_q, txf_full,
                       tx_shifter_empty_flag, rx_irq_mode_sel_q,
                       1'b0, rx_st_q == RX_IDLE, 2'b00,
                       rx_overrun_flag_q, !rxf_empty};
    assign rd_mux =
        (reg_req_in.addr == ADDR_STA) ? sta_view :
        (reg_req_in.addr == ADDR_BRG) ? baud_divisor_q :
        (reg_req_in.addr == ADDR_CFG) ? {13'h0000, cfg_q} :
        (reg_req_in.addr == ADDR_RXD) ? {8'h00, rxf_data} : 16'h0000;

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in || !reg_req_in.rd)
        begin
            rd_data_out <= 16'h0000;
        end
        else
        begin
            rd_data_out <= rd_mux;
        end
    end

    // checks
    brg_clear_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) brg_wr |=> brg_cnt_q == 16'h0000)
        else $error("baud counter not cleared by divisor write");
    brg_period_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        brg_tick && !brg_wr && $stable(baud_divisor_q)
        |=> brg_cnt_q == 16'h0000)
        else $error("baud counter did not wrap at divisor");
    os_rate_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        bit_tick |-> brg_tick
        && tx_os_q == (high_speed_baud_select ? OS_HI_MAX : OS_LO_MAX))
        else $error("wrong oversampling ratio");
    tx_mode_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        tx_irq_out |-> $past(tx_irq_mode_sel_q) != 2'b11)
        else $error("transmit irq in reserved mode");
    idle_level_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        tx_enable_bit_q && tx_st_q == TX_IDLE |=> serial_tx_pin_out
        == $past(infrared_encode_enable ? tx_idle_polarity_q : 1'b1))
        else $error("idle line level wrong");
    break_len_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        tx_st_q == TX_BRK && bit_tick && tx_enable_bit_q
        |=> (tx_st_q == TX_STOP) == ($past(tx_cnt_q) == BRK_LAST))
        else $error("break length wrong");
    tx_abort_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        !tx_enable_bit_q |=> !serial_tx_oe_out && tx_st_q == TX_IDLE
        && txf_empty)
        else $error("transmit disable did not abort");
    full_flag_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        reg_req_in.rd && reg_req_in.addr == ADDR_STA
        |=> rd_data_out[9] == $past(txf_count == TCW'(TX_DEPTH)))
        else $error("buffer full flag wrong");
    shift_empty_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        tx_load && !sta_wr |=> !tx_shifter_empty_flag [*2])
        else $error("shifter empty during transmission");
    rx_irq_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        rx_irq_out |-> $past(rx_push) && $past(rx_irq_mode_sel_q[1]
        ? rxf_count >= RCW'(RX_DEPTH - 2) : 1'b1))
        else $error("receive irq without transfer");
    overrun_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        rx_push && rxf_full |=> rx_overrun_flag_q)
        else $error("overrun not flagged");
    break_c: cover property (@(posedge sys_clk_in) brk_clr);
    rx_push_c: cover property (@(posedge sys_clk_in) rx_push);
    tx_irq_c: cover property (@(posedge sys_clk_in) tx_irq_out);
    overrun_c: cover property (@(posedge sys_clk_in) ovr_set);
endmodule

// >>> sim/uabg_remote.sv
`timescale 1ns/1ns
module uabg_remote
(
    input  wire logic clk_in,
    output logic      line_out
);
    initial line_out = 1'b1;
    // one frame: start, 8 bits lsb first, stop; line idles high
    task automatic send(input logic [7:0] b, input int bit_cyc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge clk_in);
        for (int i = 0; i < 10; i++)
        begin
            line_out <= f[i];
            repeat (bit_cyc) @(posedge clk_in);
        end
    endtask
endmodule

// >>> sim/uabg_top_tb_top.sv
`timescale 1ns/1ns
module uabg_top_tb_top;
    import uabg_pkg::*;
    logic        clk;
    logic        rst_b;
    uabg_req_t   req;
    logic [15:0] rd_data;
    logic        rx;
    logic        tx;
    logic        oe;
    logic        txi;
    logic        rxi;
    int          mismatches;
    int          samples_checked;
    int          cycles;
    int          txi_n;
    int          rxi_n;
    int          w;
    logic [15:0] v;

    uabg_top uabg_top_inst (.sys_clk_in(clk), .rst_b_in(rst_b),
        .reg_req_in(req), .rd_data_out(rd_data), .serial_rx_in(rx),
        .serial_tx_pin_out(tx), .serial_tx_oe_out(oe),
        .tx_irq_out(txi), .rx_irq_out(rxi));
    uabg_remote uabg_remote_inst (.clk_in(clk), .line_out(rx));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (txi === 1'b1)
            txi_n = txi_n + 1;
        if (rxi === 1'b1)
            rxi_n = rxi_n + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            summarize();
        end
    end

    task summarize;
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    task rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        req <= '0;
        #1 d = rd_data;
    endtask

    // length of the next low stretch on the transmit line
    task low_width(output int n);
        n = 0;
        for (int i = 0; i < 4000 && tx !== 1'b0; i++)
            @(negedge clk);
        while (tx === 1'b0 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task t_reset;
        rd(ADDR_STA, v); chk("status", v, 16'h0110);
        rd(ADDR_BRG, v); chk("divisor", v, 16'h0000);
        rd(4'h9, v); chk("unmapped", v, 16'h0000);
    endtask

    task t_tx_normal;
        wr(ADDR_BRG, 16'h0001);
        wr(ADDR_CFG, 16'h0004);
        wr(ADDR_STA, 16'h0400);
        txi_n = 0;
        wr(ADDR_TXD, 16'h00a5);
        rd(ADDR_STA, v); chk("busy", v, 16'h0410);
        low_width(w); chk("bit16", 16'(w), 16'h0020);
        chk("oe", {15'h0, oe}, 16'h0001);
        chk("txirq", 16'(txi_n), 16'h0001);
        repeat (400) @(posedge clk);
        rd(ADDR_STA, v); chk("done", v, 16'h0510);
    endtask

    task t_fast_break;
        wr(ADDR_CFG, 16'h0005);
        wr(ADDR_TXD, 16'h0002);
        low_width(w); chk("bit4", 16'(w), 16'h0010);
        repeat (100) @(posedge clk);
        wr(ADDR_STA, 16'h0c00);
        low_width(w); chk("break", 16'(w), 16'h0068);
        repeat (40) @(posedge clk);
        rd(ADDR_STA, v); chk("brkclr", v, 16'h0510);
    endtask

    task t_tx_modes;
        wr(ADDR_STA, 16'h8c00);
        txi_n = 0;
        for (int i = 0; i < 5; i++)
            wr(ADDR_TXD, 16'h0030 + 16'(i));
        rd(ADDR_STA, v); chk("full", v, 16'h8e10);
        repeat (600) @(posedge clk);
        chk("mode10", 16'(txi_n), 16'h0001);
        rd(ADDR_STA, v); chk("drained", v, 16'h8510);
        wr(ADDR_STA, 16'h2400);
        txi_n = 0;
        wr(ADDR_TXD, 16'h0041);
        wr(ADDR_TXD, 16'h0042);
        repeat (300) @(posedge clk);
        chk("mode01", 16'(txi_n), 16'h0001);
        wr(ADDR_STA, 16'h4400);
        repeat (2) @(posedge clk);
        chk("plain", {15'h0, tx}, 16'h0001);
        wr(ADDR_CFG, 16'h0007);
        repeat (2) @(posedge clk);
        chk("irhigh", {15'h0, tx}, 16'h0001);
        wr(ADDR_STA, 16'h0400);
        repeat (2) @(posedge clk);
        chk("irlow", {15'h0, tx}, 16'h0000);
        wr(ADDR_CFG, 16'h0005);
    endtask

    task t_disable;
        wr(ADDR_STA, 16'h0000);
        wr(ADDR_TXD, 16'h0055);
        repeat (2) @(posedge clk);
        chk("pin", {14'h0, oe, tx}, 16'h0001);
        rd(ADDR_STA, v); chk("dropped", v, 16'h0110);
    endtask

    task t_rx;
        rxi_n = 0;
        uabg_remote_inst.send(8'h3c, 8);
        repeat (20) @(posedge clk);
        chk("rxirq", 16'(rxi_n), 16'h0001);
        rd(ADDR_STA, v); chk("avail", v, 16'h0111);
        rd(ADDR_RXD, v); chk("rxbyte", v, 16'h003c);
        rd(ADDR_STA, v); chk("empty", v, 16'h0110);
    endtask

    task t_rx_full;
        wr(ADDR_STA, 16'h00c0);
        rxi_n = 0;
        for (int i = 0; i < 5; i++)
            uabg_remote_inst.send(8'h10 + 8'(i), 8);
        repeat (20) @(posedge clk);
        chk("fourth", 16'(rxi_n), 16'h0001);
        rd(ADDR_STA, v); chk("overrun", v, 16'h01d3);
        wr(ADDR_STA, 16'h00c0);
        rd(ADDR_STA, v); chk("ovclr", v, 16'h01d1);
        rd(ADDR_RXD, v); chk("head", v, 16'h0010);
        rd(ADDR_RXD, v); chk("next", v, 16'h0011);
        rd(ADDR_RXD, v); chk("third", v, 16'h0012);
        wr(ADDR_STA, 16'h0080);
        rxi_n = 0;
        uabg_remote_inst.send(8'h20, 8);
        uabg_remote_inst.send(8'h21, 8);
        repeat (20) @(posedge clk);
        chk("threeq", 16'(rxi_n), 16'h0001);
        rd(ADDR_STA, v); chk("rxmode10", v, 16'h0191);
    endtask

    initial
    begin
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        txi_n = 0;
        rxi_n = 0;
        req = '0;
        rst_b = 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_tx_normal();
        t_fast_break();
        t_tx_modes();
        t_disable();
        t_rx();
        t_rx_full();
        summarize();
    end
endmodule
